// ==== rtl/can_mode_pkg.sv ====
// constants and types for the can transceiver mode control block
package can_mode_pkg;
    // ******************************************************************
    // register map (byte addresses on the avalon bus)
    // ******************************************************************
    localparam logic [7:0] can_control_addr   = 8'h20;
    localparam logic [7:0] trx_status_addr    = 8'h22;
    localparam logic [7:0] wake_event_addr    = 8'h4C;
    localparam logic [7:0] bus_config_addr    = 8'h50;
    localparam logic [7:0] mode_ctrl_addr     = 8'h54;
    // ******************************************************************
    // field positions
    // ******************************************************************
    localparam int mode_lsb        = 0;
    localparam int silence_pos     = 3;
    localparam int sel_wake_pos    = 4;
    localparam int pn_valid_pos    = 5;
    localparam int fd_tol_pos      = 6;
    localparam int active_pos      = 7;
    localparam int wake_event_pos  = 0;
    localparam int wake_en_pos     = 0;
    localparam int thr_sel_lsb     = 1;
    // ******************************************************************
    // reset values
    // ******************************************************************
    localparam logic [7:0] can_control_rst = 8'h00;
    localparam logic       wake_en_rst     = 1'b1;
    localparam logic [1:0] thr_sel_rst     = 2'h0;
    // ******************************************************************
    // mode field codes
    // ******************************************************************
    localparam logic [1:0] mode_offline    = 2'h0;
    localparam logic [1:0] mode_active_uv  = 2'h1;
    localparam logic [1:0] mode_active_nuv = 2'h2;
    localparam logic [1:0] mode_listen     = 2'h3;
    // ******************************************************************
    // timing
    // ******************************************************************
    localparam int clk_mhz            = 40;
    localparam int silence_timeout_us = 1000;
    localparam int wake_window_us     = 1000;
    localparam int wake_dom_ns        = 500;
    localparam int wake_rec_ns        = 500;
    localparam int silence_cycles = silence_timeout_us * clk_mhz;
    localparam int wake_window_cycles = wake_window_us * clk_mhz;
    localparam int wake_dom_cycles = (wake_dom_ns * clk_mhz + 999) / 1000;
    localparam int wake_rec_cycles = (wake_rec_ns * clk_mhz + 999) / 1000;
    // ******************************************************************
    // types
    // ******************************************************************
    typedef enum logic [1:0] {
        chip_normal,
        chip_standby,
        chip_sleep,
        chip_reset
    } chip_mode_t;
    typedef enum logic [2:0] {
        trx_offline,
        trx_offline_bias,
        trx_listen,
        trx_active
    } trx_state_t;
    typedef enum logic [2:0] {
        wk_idle,
        wk_dom1,
        wk_rec,
        wk_dom2,
        wk_done
    } wake_state_t;
endpackage : can_mode_pkg

// ==== rtl/can_transceiver_mode_control.sv ====
// can transceiver mode control, bus bias and standard pattern wake-up
`timescale 1ns/1ps
//Function
//- mode field 01 or 10 selects active mode, transmit and receive
//- with code 01, can supply undervoltage drops active to offline bias, or to offline on a silent bus
//- with code 10, supply check off; main supply reset holds transmitter off
//- txd low at active request gives listen-only until txd goes high
//- in normal chip mode the transceiver follows the mode field
//- standby or sleep forces offline or offline bias by bus activity
//- listen-only keeps transmitter off, receiver and bias on
//- offline grounds bus bias; wake watch only with wake enable
//- offline goes to offline bias on edges, back after silence
//- active mode passes bus data to rxd and txd to the bus
//- pattern watch runs offline, wake enabled, selective off or pn invalid
//- dominant, recessive, dominant within wake window, minimum phase lengths
//- valid pattern sets wake event flag and drives rxd low
//- wake during sleep enables main supply and passes reset to standby
//- readable flag shows whether the transceiver is in active mode
//- control bit 6 holds fd tolerance enable
//- control bit 5 holds pn configuration valid flag
//- control bit 4 enables selective wake-up
//- mode field bits 1:0 decode offline, active, active, listen-only
//- status bit 3 shows bus silence longer than the time-out
module can_transceiver_mode_control #(
    parameter int silence_cnt   = can_mode_pkg::silence_cycles,
    parameter int wake_win_cnt  = can_mode_pkg::wake_window_cycles,
    parameter int wake_dom_cnt  = can_mode_pkg::wake_dom_cycles,
    parameter int wake_rec_cnt  = can_mode_pkg::wake_rec_cycles,
    parameter int reset_cnt     = 16
) (
    input  wire logic                     core_clk,
    input  wire logic                     rst,
    input  wire logic [7:0]               avs_address,
    input  wire logic                     avs_read,
    input  wire logic                     avs_write,
    input  wire logic [31:0]              avs_writedata,
    input  wire logic [3:0]               avs_byteenable,
    output logic      [31:0]              avs_readdata,
    output logic                          avs_waitrequest,
    output logic                          avs_response_err,
    input  wire logic                     txd,
    output logic                          rxd,
    input  wire logic                     bus_rx,
    output logic                          bus_tx_dominant,
    output logic                          tx_enable,
    output logic                          bias_mid,
    output logic                          bias_gnd,
    input  wire logic                     can_supply_low,
    input  wire logic                     main_supply_low,
    input  wire logic                     go_normal,
    input  wire logic                     go_standby,
    input  wire logic                     go_sleep,
    output can_mode_pkg::chip_mode_t      chip_mode,
    output logic                          main_supply_enable,
    output can_mode_pkg::trx_state_t      trx_state
);
    import can_mode_pkg::*;

    initial begin
        if (silence_cnt < 2 || wake_win_cnt < 2 || wake_dom_cnt < 1 || wake_rec_cnt < 1
            || reset_cnt < 1 || silence_cnt >= 2**24 || wake_win_cnt >= 2**24
            || reset_cnt >= 2**24) begin
            $error("can_transceiver_mode_control: bad timing parameter");
        end
    end

    // ******************************************************************
    // registers
    // ******************************************************************
    logic [7:0]  can_control;
    logic        can_wake_enable;
    logic [1:0]  main_supply_reset_threshold_sel;
    logic        can_wake_event;

    logic        bus_silence_flag;
    logic        bus_prev;
    logic        bus_edge;

    logic [23:0] silence_count;
    logic [23:0] win_count;
    logic [23:0] phase_count;
    logic [23:0] reset_count;

    logic        wake_detect;
    logic        pattern_watch;

    logic        active_req;
    logic        ack;
    logic        hit;
    wake_state_t wake_state;

    wire [1:0]   can_mode_field        = can_control[mode_lsb+1:mode_lsb];
    wire         selective_wake_enable = can_control[sel_wake_pos];
    wire         pn_config_valid       = can_control[pn_valid_pos];
    wire         fd_tolerance_enable   = can_control[fd_tol_pos];

    // ******************************************************************
    // avalon slave: one wait cycle, answer on the second cycle
    // ******************************************************************
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ack <= 1'b0;
        end else begin
            ack <= (avs_read || avs_write) && !ack;
        end
    end

    assign avs_waitrequest = (avs_read || avs_write) && !ack;
    wire do_write = avs_write && ack;
    wire do_read  = avs_read && ack;

    always_comb begin
        hit = 1'b1;
        case (avs_address)
            can_control_addr, trx_status_addr, wake_event_addr,
            bus_config_addr, mode_ctrl_addr: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end

    // fd tolerance is stored only; the bit has no effect on pattern wake-up
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            can_control <= can_control_rst;
        end else if (do_write && avs_address == can_control_addr && avs_byteenable[0]) begin
            // bits 3:2 are read-only and stay zero
            can_control <= avs_writedata[7:0] & 8'hF3;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            can_wake_enable                 <= wake_en_rst;
            main_supply_reset_threshold_sel <= thr_sel_rst;
        end else if (do_write && avs_address == bus_config_addr && avs_byteenable[0]) begin
            can_wake_enable                 <= avs_writedata[wake_en_pos];
            main_supply_reset_threshold_sel <= avs_writedata[thr_sel_lsb+1:thr_sel_lsb];
        end
    end

    // write one to clear; a detection in the same cycle wins
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            can_wake_event <= 1'b0;
        end else if (wake_detect) begin
            can_wake_event <= 1'b1;
        end else if (do_write && avs_address == wake_event_addr && avs_byteenable[0]
                     && avs_writedata[wake_event_pos]) begin
            can_wake_event <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            avs_readdata     <= 32'h0;
            avs_response_err <= 1'b0;
        end else begin
            avs_response_err <= (avs_read || avs_write) && !ack && !hit;
            avs_readdata     <= 32'h0;
            if ((avs_read && !ack)) begin
                case (avs_address)
                    can_control_addr: avs_readdata <= {24'h0, can_control};
                    trx_status_addr: avs_readdata <= {24'h0, (trx_state == trx_active), 3'h0,
                                                      bus_silence_flag, 3'h0};
                    wake_event_addr: avs_readdata <= {31'h0, can_wake_event};
                    bus_config_addr: avs_readdata <= {29'h0, main_supply_reset_threshold_sel,
                                                      can_wake_enable};
                    mode_ctrl_addr:  avs_readdata <= {30'h0, chip_mode};
                    default:         avs_readdata <= 32'h0;
                endcase
            end
        end
    end

    // ******************************************************************
    // bus activity and silence time-out
    // ******************************************************************
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            bus_prev <= 1'b1;
        end else begin
            bus_prev <= bus_rx;
        end
    end

    assign bus_edge = bus_prev != bus_rx;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            silence_count    <= 24'h0;
            bus_silence_flag <= 1'b1;
        end else if (bus_edge) begin
            silence_count    <= 24'h0;
            bus_silence_flag <= 1'b0;
        end else if (silence_count < 24'(silence_cnt)) begin
            silence_count <= silence_count + 24'h1;
        end else begin
            bus_silence_flag <= 1'b1;
        end
    end

    // ******************************************************************
    // chip mode: sleep wake passes reset mode into standby
    // ******************************************************************
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            chip_mode   <= chip_standby;
            reset_count <= 24'h0;
        end else begin
            case (chip_mode)
                chip_sleep: begin
                    if (wake_detect) begin
                        chip_mode   <= chip_reset;
                        reset_count <= 24'h0;
                    end else if (go_normal) begin
                        chip_mode <= chip_normal;
                    end
                end
                chip_reset: begin
                    if (reset_count >= 24'(reset_cnt - 1)) begin
                        chip_mode <= chip_standby;
                    end else begin
                        reset_count <= reset_count + 24'h1;
                    end
                end
                default: begin
                    if (go_sleep) begin
                        chip_mode <= chip_sleep;
                    end else if (go_standby) begin
                        chip_mode <= chip_standby;
                    end else if (go_normal) begin
                        chip_mode <= chip_normal;
                    end
                end
            endcase
        end
    end

    assign main_supply_enable = chip_mode != chip_sleep;

    // ******************************************************************
    // transceiver state
    // ******************************************************************
    always_comb begin
        active_req = 1'b0;
        case (can_mode_field)
            mode_active_uv:  active_req = !can_supply_low && !main_supply_low;
            mode_active_nuv: active_req = !main_supply_low;
            default:         active_req = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            trx_state <= trx_offline;
        end else if (chip_mode == chip_normal && can_mode_field != mode_offline
                     && !(active_req == 1'b0 && can_mode_field != mode_listen)) begin
            if (can_mode_field == mode_listen) begin
                trx_state <= trx_listen;
            end else if (trx_state == trx_active || txd) begin
                trx_state <= trx_active;
            end else begin
                trx_state <= trx_listen;
            end
        end else begin
            // offline side, also forced in standby and sleep
            if (bus_edge) begin
                trx_state <= trx_offline_bias;
            end else if (bus_silence_flag) begin
                trx_state <= trx_offline;
            end else if (trx_state != trx_offline) begin
                trx_state <= trx_offline_bias;
            end
        end
    end

    assign tx_enable       = trx_state == trx_active;
    assign bus_tx_dominant = tx_enable && !txd;
    assign bias_mid        = trx_state != trx_offline;
    assign bias_gnd        = trx_state == trx_offline;

    // outside active and listen, rxd stays low after a wake until the event flag is cleared
    assign rxd = (trx_state == trx_active || trx_state == trx_listen) ? bus_rx
               : !can_wake_event;

    // ******************************************************************
    // standard pattern wake-up filter
    // ******************************************************************
    assign pattern_watch = (trx_state == trx_offline || trx_state == trx_offline_bias)
                        && can_wake_enable
                        && (!selective_wake_enable || !pn_config_valid);

    // short opposite pulses restart the phase count but keep the phase
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wake_state  <= wk_idle;
            phase_count <= 24'h0;
            win_count   <= 24'h0;
        end else if (!pattern_watch) begin
            wake_state <= wk_idle;
        end else begin
            case (wake_state)
                wk_idle: begin
                    win_count   <= 24'h0;
                    phase_count <= 24'h0;
                    if (!bus_rx) begin
                        wake_state <= wk_dom1;
                    end
                end
                wk_dom1, wk_rec, wk_dom2: begin
                    win_count <= win_count + 24'h1;
                    if (win_count >= 24'(wake_win_cnt - 1)) begin
                        wake_state <= wk_idle;
                    end else if (bus_edge) begin
                        phase_count <= 24'h0;
                    end else begin
                        phase_count <= phase_count + 24'h1;
                        if (wake_state == wk_dom1 && !bus_rx
                            && phase_count >= 24'(wake_dom_cnt - 1)) begin
                            wake_state  <= wk_rec;
                            phase_count <= 24'h0;
                        end else if (wake_state == wk_rec && bus_rx
                            && phase_count >= 24'(wake_rec_cnt - 1)) begin
                            wake_state  <= wk_dom2;
                            phase_count <= 24'h0;
                        end else if (wake_state == wk_dom2 && !bus_rx
                            && phase_count >= 24'(wake_dom_cnt - 1)) begin
                            wake_state <= wk_done;
                        end
                    end
                end
                wk_done: begin
                    wake_state <= wk_idle;
                end
                default: wake_state <= wk_idle;
            endcase
        end
    end

    assign wake_detect = wake_state == wk_done;
endmodule : can_transceiver_mode_control

// ==== verif/can_mode_monitor.sv ====
// assertion checker watching the can transceiver mode control ports
`timescale 1ns/1ps
module can_mode_monitor #(
    parameter int silence_cnt = 20
) (
    input wire logic                     core_clk,
    input wire logic                     rst,
    input wire logic                     txd,
    input wire logic                     rxd,
    input wire logic                     bus_rx,
    input wire logic                     bus_tx_dominant,
    input wire logic                     tx_enable,
    input wire logic                     bias_mid,
    input wire logic                     bias_gnd,
    input wire logic                     main_supply_enable,
    input wire can_mode_pkg::chip_mode_t chip_mode,
    input wire can_mode_pkg::trx_state_t trx_state
);
    import can_mode_pkg::*;
    // ******************************************************************
    // bus quiet counter, saturates so it never wraps on long idle
    // ******************************************************************
    logic prev_rx;
    int   quiet;
    logic low_power;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            prev_rx <= 1'b1;
            quiet   <= 0;
        end else begin
            prev_rx <= bus_rx;
            if (bus_rx != prev_rx) begin
                quiet <= 0;
            end else if (quiet < silence_cnt + 8) begin
                quiet <= quiet + 1;
            end
        end
    end
    assign low_power = chip_mode == chip_standby || chip_mode == chip_sleep;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // ******************************************************************
    // properties
    // ******************************************************************
    sequence s_edge_offline;
        trx_state == trx_offline && low_power && $changed(bus_rx);
    endsequence
    sequence s_wake_exit;
        chip_mode == chip_sleep ##1 chip_mode == chip_reset;
    endsequence
    property p_lp_offline;
        low_power && $past(low_power) |-> trx_state inside {trx_offline, trx_offline_bias};
    endproperty
    property p_txd_hold;
        !txd && trx_state != trx_active |=> trx_state != trx_active;
    endproperty
    property p_listen;
        trx_state == trx_listen |-> !tx_enable && !bus_tx_dominant && bias_mid;
    endproperty
    property p_offline_gnd;
        trx_state == trx_offline |-> bias_gnd && !bias_mid && !tx_enable;
    endproperty
    property p_active_path;
        trx_state == trx_active |-> rxd == bus_rx && bus_tx_dominant == !txd;
    endproperty
    property p_bias_on_edge;
        s_edge_offline |-> ##[1:2] trx_state == trx_offline_bias;
    endproperty
    property p_silence_back;
        quiet > silence_cnt + 3 && low_power && $past(low_power) |-> trx_state == trx_offline;
    endproperty
    property p_wake_exit;
        s_wake_exit |-> main_supply_enable ##[1:8] chip_mode == chip_standby;
    endproperty
    a_lp_offline: assert property (p_lp_offline) else $error("active in low power");
    a_txd_hold: assert property (p_txd_hold) else $error("active with txd low");
    a_listen: assert property (p_listen) else $error("listen drives bus");
    a_offline_gnd: assert property (p_offline_gnd) else $error("offline bias wrong");
    a_active_path: assert property (p_active_path) else $error("active path wrong");
    a_bias_on_edge: assert property (p_bias_on_edge) else $error("no bias on edge");
    a_silence_back: assert property (p_silence_back) else $error("no offline on silence");
    a_wake_exit: assert property (p_wake_exit) else $error("sleep exit wrong");
endmodule : can_mode_monitor

bind can_transceiver_mode_control can_mode_monitor #(.silence_cnt(silence_cnt)) i_mon (
    .core_clk, .rst, .txd, .rxd, .bus_rx, .bus_tx_dominant, .tx_enable, .bias_mid,
    .bias_gnd, .main_supply_enable, .chip_mode, .trx_state);

// ==== verif/can_bus_partner.sv ====
// behavioural protocol controller and bus with one remote node
`timescale 1ns/1ps
module can_bus_partner (
    input  wire logic core_clk,
    input  wire logic bus_tx_dominant,
    input  wire logic ctl_txd,
    output logic      txd,
    output logic      bus_rx
);
    logic node_dom = 1'b0;
    assign txd = ctl_txd;
    // wired bus: any dominant driver pulls the line low, recessive otherwise
    assign bus_rx = !(bus_tx_dominant || node_dom);
    // remote node sends dominant, recessive, dominant phases of given lengths
    task automatic send_wake(input int d1, input int r, input int d2);
        node_dom <= 1'b1;
        repeat (d1) @(posedge core_clk);
        node_dom <= 1'b0;
        repeat (r) @(posedge core_clk);
        node_dom <= 1'b1;
        repeat (d2) @(posedge core_clk);
        node_dom <= 1'b0;
    endtask : send_wake
endmodule : can_bus_partner

// ==== verif/testbench.sv ====
// self-checking bench for the can transceiver mode control block
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; \
    $display("[ERR] t=%0t got %h exp %h", $time, (a), (b)); end end
module testbench;
    import can_mode_pkg::*;
    logic core_clk = 1'b0, rst = 1'b1, ctl_txd = 1'b1, txd, rxd, bus_rx, bus_tx_dominant;
    logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest, avs_response_err, rd_err;
    logic [7:0]  avs_address = 8'h00;
    logic [3:0]  avs_byteenable = 4'hF;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd_q;
    logic can_supply_low = 1'b0, main_supply_low = 1'b0, main_supply_enable;
    logic go_normal = 1'b0, go_standby = 1'b0, go_sleep = 1'b0;
    logic tx_enable, bias_mid, bias_gnd, seen_reset;
    chip_mode_t chip_mode;
    trx_state_t trx_state;
    int errors = 0, compares = 0;
    always #12.5 core_clk = ~core_clk;
    can_transceiver_mode_control #(.silence_cnt(20), .wake_win_cnt(200), .wake_dom_cnt(3),
        .wake_rec_cnt(3), .reset_cnt(4)) i_can_transceiver_mode_control (
        .core_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response_err, .txd, .rxd,
        .bus_rx, .bus_tx_dominant, .tx_enable, .bias_mid, .bias_gnd, .can_supply_low,
        .main_supply_low, .go_normal, .go_standby, .go_sleep, .chip_mode, .main_supply_enable,
        .trx_state);
    can_bus_partner i_can_bus_partner (.core_clk, .bus_tx_dominant, .ctl_txd, .txd, .bus_rx);
    task automatic final_report;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report
    // look mid low phase after n edges
    task automatic look(input int n);
        repeat (n) @(posedge core_clk);
        @(negedge core_clk);
    endtask : look
    task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
        int n;
        @(posedge core_clk);
        avs_address   <= a;
        avs_writedata <= {24'h0, d};
        avs_write     <= wr;
        avs_read      <= !wr;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (avs_waitrequest !== 1'b0) begin
            errors++;
            final_report();
        end
        rd_q   = avs_readdata;
        rd_err = avs_response_err;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask : acc
    task automatic t_regs;
        acc(1'b0, can_control_addr, 8'h00);
        `CHK(rd_q, 32'h0)
        acc(1'b1, can_control_addr, 8'hFF);
        avs_byteenable <= 4'hE;
        acc(1'b1, can_control_addr, 8'h00);
        avs_byteenable <= 4'hF;
        acc(1'b0, can_control_addr, 8'h00);
        `CHK(rd_q, 32'hF3)
        acc(1'b0, trx_status_addr, 8'h00);
        `CHK({rd_q[active_pos], rd_q[silence_pos]}, 2'b01)
        acc(1'b0, 8'h30, 8'h00);
        `CHK({rd_err, rd_q}, {1'b1, 32'h0})
        acc(1'b1, can_control_addr, 8'h00);
    endtask : t_regs
    task automatic t_modes;
        trx_state_t exp_st[4] = '{trx_offline, trx_active, trx_active, trx_listen};
        @(posedge core_clk);
        go_normal <= 1'b1;
        look(4);
        for (int c = 0; c < 4; c++) begin
            acc(1'b1, can_control_addr, 8'(c));
            look(2);
            `CHK(trx_state, exp_st[c])
            `CHK(tx_enable, exp_st[c] == trx_active)
            acc(1'b0, trx_status_addr, 8'h00);
            `CHK(rd_q[active_pos], exp_st[c] == trx_active)
        end
    endtask : t_modes
    task automatic t_tx;
        acc(1'b1, can_control_addr, {6'h0, mode_active_uv});
        @(posedge core_clk);
        ctl_txd <= 1'b0;
        look(0);
        `CHK({bus_tx_dominant, rxd}, 2'b10)
        acc(1'b1, can_control_addr, {6'h0, mode_offline});
        acc(1'b1, can_control_addr, {6'h0, mode_active_uv});
        look(2);
        `CHK(trx_state, trx_listen)
        @(posedge core_clk);
        ctl_txd <= 1'b1;
        look(2);
        `CHK(trx_state, trx_active)
        @(posedge core_clk);
        can_supply_low <= 1'b1;
        look(2);
        `CHK(trx_state, trx_offline_bias)
        acc(1'b1, can_control_addr, {6'h0, mode_active_nuv});
        look(2);
        `CHK(trx_state, trx_active)
        @(posedge core_clk);
        main_supply_low <= 1'b1;
        look(2);
        `CHK(tx_enable, 1'b0)
        @(posedge core_clk);
        main_supply_low <= 1'b0;
        can_supply_low  <= 1'b0;
    endtask : t_tx
    task automatic wake_try(input logic [7:0] en, input logic [7:0] ctl, input int d1,
                            input logic exp);
        acc(1'b1, bus_config_addr, en);
        acc(1'b1, can_control_addr, ctl);
        @(posedge core_clk);
        i_can_bus_partner.send_wake(d1, 5, 5);
        look(4);
        `CHK(rxd, !exp)
        acc(1'b0, wake_event_addr, 8'h00);
        `CHK(rd_q[wake_event_pos], exp)
        acc(1'b1, wake_event_addr, 8'h01);
    endtask : wake_try
    task automatic t_wake;
        @(posedge core_clk);
        go_normal  <= 1'b0;
        go_standby <= 1'b1;
        look(30);
        `CHK({chip_mode, trx_state, bias_gnd}, {chip_standby, trx_offline, 1'b1})
        wake_try(8'h01, 8'h00, 1, 1'b0);
        wake_try(8'h00, 8'h00, 5, 1'b0);
        wake_try(8'h01, 8'h00, 5, 1'b1);
        wake_try(8'h01, 8'h30, 5, 1'b0);
        wake_try(8'h01, 8'h10, 5, 1'b1);
        acc(1'b1, can_control_addr, 8'h00);
    endtask : t_wake
    task automatic t_sleep;
        int n;
        @(posedge core_clk);
        go_standby <= 1'b0;
        go_sleep   <= 1'b1;
        look(30);
        `CHK({chip_mode, main_supply_enable}, {chip_sleep, 1'b0})
        @(posedge core_clk);
        go_sleep <= 1'b0;
        i_can_bus_partner.send_wake(5, 5, 5);
        seen_reset = 1'b0;
        for (n = 0; n < 60 && chip_mode !== chip_standby; n++) begin
            look(0);
            seen_reset |= chip_mode === chip_reset;
        end
        `CHK({seen_reset, chip_mode, main_supply_enable}, {1'b1, chip_standby, 1'b1})
    endtask : t_sleep
    initial begin
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        t_regs();
        t_modes();
        t_tx();
        t_wake();
        t_sleep();
        final_report();
    end
endmodule : testbench
